// ==== tdg_display_timing.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tdg_params.svh"

module tdg_display_timing (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic caret_on_line,
  input wire tdg_pkg::tdg_addr_t alt_addr,
  output tdg_pkg::tdg_dot_t dot_count_bits,
  output logic last_dot_flag,
  output logic dot_tick,
  output tdg_pkg::tdg_char_t char_count_bits,
  output tdg_pkg::tdg_row_t row_count_bits,
  output tdg_pkg::tdg_line_t line_number_bits,
  output logic cursor_row_latch,
  output logic preset_load_window,
  output logic refresh_gate,
  output tdg_pkg::tdg_addr_t refresh_addr
);
  import tdg_pkg::*;

  // ---------------------------------------------------------------
  // Dot generator
  // ---------------------------------------------------------------
  tdg_dot_if dot ();

  tdg_dot_gen u_dot (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .dot(dot.gen)
  );

  logic char_tick;
  tdg_char_t char_r;
  tdg_char_t char_nxt;
  tdg_row_t row_r;
  tdg_line_t line_r;
  logic cursor_r;
  logic caret_meta_r;
  logic caret_sync_r;
  logic row_end;
  logic final_row;
  logic line_end;
  logic screen_end;
  logic load_win_r;
  logic adv_latch_r;
  tdg_addr_t vaddr_r;
  tdg_addr_t preset_r;
  logic refresh_gate_r;
  tdg_addr_t refresh_addr_r;
  logic last_dot_r;
  logic dot_tick_r;

  assign char_tick = dot.dot_en && dot.last_dot;
  assign char_nxt = (char_r == `TDG_CHAR_LAST) ? 7'h00 : 7'(char_r + 7'h01);
  assign row_end = char_tick && (char_r == `TDG_CHAR_LAST);
  assign final_row = cursor_r ? (row_r == `TDG_ROW_LAST_CUR) : (row_r == `TDG_ROW_LAST);
  assign line_end = row_end && final_row;
  assign screen_end = row_end && (line_r == `TDG_LINE_LAST) && (row_r == `TDG_LINE_LAST_ROW);

  // ---------------------------------------------------------------
  // Caret input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      caret_meta_r <= 1'b0;
      caret_sync_r <= 1'b0;
    end else begin
      caret_meta_r <= caret_on_line;
      caret_sync_r <= caret_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Character counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      char_r <= 7'h00;
    end else if (char_tick) begin
      char_r <= char_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Row and line counters
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      row_r <= 4'h0;
      line_r <= 5'h00;
    end else if (screen_end) begin
      row_r <= 4'h0;
      line_r <= 5'h00;
    end else if (line_end) begin
      row_r <= 4'h0;
      line_r <= 5'(line_r + 5'h01);
    end else if (row_end) begin
      row_r <= 4'(row_r + 4'h1);
    end
  end

  // ---------------------------------------------------------------
  // Cursor latch: one extra row for caret painting
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cursor_r <= 1'b0;
    end else if (line_end || screen_end) begin
      cursor_r <= 1'b0;
    end else if (dot.dot_en && row_r == `TDG_ROW_LAST && caret_sync_r) begin
      cursor_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Load window
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      load_win_r <= 1'b0;
    end else if (char_tick && char_nxt == `TDG_CT_WIN_ON) begin
      load_win_r <= 1'b1;
    end else if (char_tick && char_nxt == `TDG_CT_WIN_OFF) begin
      load_win_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Video address counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vaddr_r <= `TDG_ADDR_RST;
    end else if (char_tick) begin
      if (char_nxt == `TDG_CT_CLR) begin
        vaddr_r <= `TDG_ADDR_RST;
      end else if (load_win_r) begin
        if (char_r == `TDG_CT_LOAD && line_r < `TDG_LINE_NO_PRESET) begin
          vaddr_r <= preset_r;
        end
      end else if (char_nxt != `TDG_CT_WIN_ON) begin
        vaddr_r <= 11'(vaddr_r + 11'h001);
      end
    end
  end

  // ---------------------------------------------------------------
  // Preset advance latch: ten characters on a line's final row
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      adv_latch_r <= 1'b0;
    end else if (char_tick && char_nxt == `TDG_CT_ADV_OFF) begin
      adv_latch_r <= 1'b0;
    end else if (char_tick && char_nxt == `TDG_CT_ADV_ON && final_row &&
                 line_r < `TDG_LINE_NO_PRESET) begin
      adv_latch_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Preset counter: eight dot pulses per character while latched
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      preset_r <= `TDG_ADDR_RST;
    end else if (line_r == `TDG_LINE_LAST && row_r == 4'h0) begin
      preset_r <= `TDG_ADDR_RST;
    end else if (adv_latch_r && dot.dot_en && !dot.last_dot) begin
      preset_r <= 11'(preset_r + 11'h001);
    end
  end

  // ---------------------------------------------------------------
  // Refresh address select
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      refresh_gate_r <= 1'b0;
      refresh_addr_r <= `TDG_ADDR_RST;
    end else begin
      refresh_gate_r <= !load_win_r && row_r < `TDG_ROW_LAST;
      refresh_addr_r <= (!load_win_r && row_r < `TDG_ROW_LAST) ? vaddr_r : alt_addr;
    end
  end

  // ---------------------------------------------------------------
  // Registered dot enable and end-of-character pulse (dot_en && last_dot)
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      last_dot_r <= 1'b0;
      dot_tick_r <= 1'b0;
    end else begin
      last_dot_r <= char_tick;
      dot_tick_r <= dot.dot_en;
    end
  end

  assign dot_count_bits = dot.dot_count;
  assign last_dot_flag = last_dot_r;
  assign dot_tick = dot_tick_r;
  assign char_count_bits = char_r;
  assign row_count_bits = row_r;
  assign line_number_bits = line_r;
  assign cursor_row_latch = cursor_r;
  assign preset_load_window = load_win_r;
  assign refresh_gate = refresh_gate_r;
  assign refresh_addr = refresh_addr_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_char_end;
    char_tick && char_r != `TDG_CHAR_LAST;
  endsequence

  sequence s_row_end_plain;
    row_end && !line_end && !screen_end;
  endsequence

  sequence s_enter_win;
    char_tick && char_nxt == `TDG_CT_WIN_ON;
  endsequence

  sequence s_leave_win;
    char_tick && char_nxt == `TDG_CT_WIN_OFF;
  endsequence

  property p_char_step;
    @(posedge sys_clk) disable iff (!resetn)
      s_char_end |=> (char_r == 7'($past(char_r) + 7'h01));
  endproperty
  a_char_step: assert property (p_char_step) else $error("char count did not step");

  property p_char_wrap;
    @(posedge sys_clk) disable iff (!resetn)
      (char_tick && char_r == `TDG_CHAR_LAST) |=> (char_r == 7'h00);
  endproperty
  a_char_wrap: assert property (p_char_wrap) else $error("char count did not clear at 96");

  property p_row_step;
    @(posedge sys_clk) disable iff (!resetn)
      s_row_end_plain |=> (row_r == 4'($past(row_r) + 4'h1)) && (char_r == 7'h00);
  endproperty
  a_row_step: assert property (p_row_step) else $error("row did not step with char clear");

  property p_cur_set;
    @(posedge sys_clk) disable iff (!resetn)
      (dot.dot_en && row_r == `TDG_ROW_LAST && caret_sync_r && !row_end) |=> cursor_r;
  endproperty
  a_cur_set: assert property (p_cur_set) else $error("cursor latch not set at row 11");

  property p_line_plain;
    @(posedge sys_clk) disable iff (!resetn)
      (row_end && !cursor_r && row_r == `TDG_ROW_LAST && !screen_end)
        |=> (row_r == 4'h0) && (line_r == 5'($past(line_r) + 5'h01));
  endproperty
  a_line_plain: assert property (p_line_plain) else $error("line not advanced after row 11");

  property p_line_cur;
    @(posedge sys_clk) disable iff (!resetn)
      (row_end && cursor_r && row_r == `TDG_ROW_LAST) |=> (row_r == `TDG_ROW_LAST_CUR);
  endproperty
  a_line_cur: assert property (p_line_cur) else $error("extra cursor row skipped");

  property p_screen_end;
    @(posedge sys_clk) disable iff (!resetn)
      screen_end |=> (row_r == 4'h0) && (line_r == 5'h00);
  endproperty
  a_screen_end: assert property (p_screen_end) else $error("screen did not restart");

  property p_win;
    @(posedge sys_clk) disable iff (!resetn)
      s_enter_win |=> load_win_r;
  endproperty
  a_win: assert property (p_win) else $error("load window not raised at 78");

  property p_win_off;
    @(posedge sys_clk) disable iff (!resetn)
      s_leave_win |=> !load_win_r;
  endproperty
  a_win_off: assert property (p_win_off) else $error("load window not dropped at 95");

  property p_load;
    @(posedge sys_clk) disable iff (!resetn)
      (char_tick && load_win_r && char_r == `TDG_CT_LOAD && line_r < `TDG_LINE_NO_PRESET)
        |=> (vaddr_r == $past(preset_r));
  endproperty
  a_load: assert property (p_load) else $error("preset not copied at 93");

  property p_inc;
    @(posedge sys_clk) disable iff (!resetn)
      (char_tick && !load_win_r && char_nxt != `TDG_CT_WIN_ON && char_nxt != `TDG_CT_CLR)
        |=> (vaddr_r == 11'($past(vaddr_r) + 11'h001));
  endproperty
  a_inc: assert property (p_inc) else $error("address did not step");

  property p_clr89;
    @(posedge sys_clk) disable iff (!resetn)
      (char_tick && char_nxt == `TDG_CT_CLR) |=> (vaddr_r == `TDG_ADDR_RST);
  endproperty
  a_clr89: assert property (p_clr89) else $error("address not cleared at 89");

  property p_preset_hold;
    @(posedge sys_clk) disable iff (!resetn)
      (!adv_latch_r && !(line_r == `TDG_LINE_LAST && row_r == 4'h0)) |=> $stable(preset_r);
  endproperty
  a_preset_hold: assert property (p_preset_hold) else $error("preset moved mid line");

  property p_preset_clr;
    @(posedge sys_clk) disable iff (!resetn)
      (line_r == `TDG_LINE_LAST && row_r == 4'h0) |=> (preset_r == `TDG_ADDR_RST);
  endproperty
  a_preset_clr: assert property (p_preset_clr) else $error("preset not cleared on line 25");

  property p_no_adv_late;
    @(posedge sys_clk) disable iff (!resetn)
      (line_r >= `TDG_LINE_NO_PRESET && !adv_latch_r) |=> !adv_latch_r;
  endproperty
  a_no_adv_late: assert property (p_no_adv_late) else $error("preset advanced past line 24");

  property p_refresh_src;
    @(posedge sys_clk) disable iff (!resetn)
      (!load_win_r && row_r < `TDG_ROW_LAST) |=> (refresh_gate_r && refresh_addr_r == $past(vaddr_r));
  endproperty
  a_refresh_src: assert property (p_refresh_src) else $error("refresh address not from counter");

endmodule : tdg_display_timing

`default_nettype wire

// ==== tdg_params.svh ====
`ifndef TDG_PARAMS_SVH
`define TDG_PARAMS_SVH

// ---------------------------------------------------------------
// Clock rates (kHz) for the dot-rate accumulator
// ---------------------------------------------------------------
`define TDG_SYS_KHZ 18'h30D40
`define TDG_PIX_KHZ 18'h034AF

// ---------------------------------------------------------------
// Counter end values
// ---------------------------------------------------------------
`define TDG_DOT_LAST 4'h8
`define TDG_CHAR_LAST 7'h60
`define TDG_ROW_LAST 4'hB
`define TDG_ROW_LAST_CUR 4'hC
`define TDG_LINE_LAST 5'h19
`define TDG_LINE_LAST_ROW 4'h7
`define TDG_LINE_NO_PRESET 5'h18

// ---------------------------------------------------------------
// Character times of the address generator
// ---------------------------------------------------------------
`define TDG_CT_WIN_ON 7'h4E
`define TDG_CT_WIN_OFF 7'h5F
`define TDG_CT_LOAD 7'h5D
`define TDG_CT_CLR 7'h59
`define TDG_CT_ADV_ON 7'h50
`define TDG_CT_ADV_OFF 7'h5A

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define TDG_ADDR_RST 11'h000

`endif

// ==== tdg_pkg.sv ====
package tdg_pkg;
  typedef logic [3:0] tdg_dot_t;
  typedef logic [6:0] tdg_char_t;
  typedef logic [3:0] tdg_row_t;
  typedef logic [4:0] tdg_line_t;
  typedef logic [10:0] tdg_addr_t;
endpackage : tdg_pkg

// ==== tdg_dot_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface tdg_dot_if;
  import tdg_pkg::*;
  logic dot_en;
  tdg_dot_t dot_count;
  logic last_dot;

  modport gen (
    output dot_en,
    output dot_count,
    output last_dot
  );
  modport use_side (
    input dot_en,
    input dot_count,
    input last_dot
  );
endinterface : tdg_dot_if

`default_nettype wire

// ==== tdg_dot_gen.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tdg_params.svh"

module tdg_dot_gen (
  input wire logic sys_clk,
  input wire logic resetn,
  tdg_dot_if.gen dot
);
  import tdg_pkg::*;

  logic [17:0] acc_r;
  logic [17:0] acc_sum;
  logic dot_en_r;
  tdg_dot_t dot_count_r;

  assign acc_sum = acc_r + `TDG_PIX_KHZ;

  // ---------------------------------------------------------------
  // Dot-rate enable from fractional accumulator
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_r <= 18'h00000;
      dot_en_r <= 1'b0;
    end else if (acc_sum >= `TDG_SYS_KHZ) begin
      acc_r <= acc_sum - `TDG_SYS_KHZ;
      dot_en_r <= 1'b1;
    end else begin
      acc_r <= acc_sum;
      dot_en_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Dot counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dot_count_r <= 4'h0;
    end else if (dot_en_r) begin
      if (dot_count_r == `TDG_DOT_LAST) begin
        dot_count_r <= 4'h0;
      end else begin
        dot_count_r <= dot_count_r + 4'h1;
      end
    end
  end

  assign dot.dot_en = dot_en_r;
  assign dot.dot_count = dot_count_r;
  assign dot.last_dot = (dot_count_r == `TDG_DOT_LAST);

  property p_dot_wrap;
    @(posedge sys_clk) disable iff (!resetn)
      (dot_en_r && dot_count_r == `TDG_DOT_LAST) |=> (dot_count_r == 4'h0);
  endproperty
  a_dot_wrap: assert property (p_dot_wrap) else $error("dot counter did not wrap after 8");

  property p_dot_range;
    @(posedge sys_clk) disable iff (!resetn)
      (dot_en_r && dot_count_r != `TDG_DOT_LAST) |=> (dot_count_r == 4'($past(dot_count_r) + 4'h1));
  endproperty
  a_dot_range: assert property (p_dot_range) else $error("dot counter did not step by one");

endmodule : tdg_dot_gen

`default_nettype wire

// ==== tdg_refresh_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Refresh storage model: records each screen refresh burst
// ---------------------------------------------------------------
module tdg_refresh_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire tdg_pkg::tdg_dot_t dot_count_bits,
  input wire logic refresh_gate,
  input wire tdg_pkg::tdg_addr_t refresh_addr,
  output logic [7:0] burst_len,
  output tdg_pkg::tdg_addr_t burst_first,
  output tdg_pkg::tdg_addr_t burst_last,
  output logic [7:0] burst_num,
  output logic [7:0] gap_errs
);
  import tdg_pkg::*;

  tdg_dot_t dot_r;
  logic gate_r;
  logic [7:0] len_r;
  tdg_addr_t first_r;
  tdg_addr_t prev_r;

  // Mid-character read, well after the address has settled
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dot_r <= 4'h0;
      gate_r <= 1'b0;
      len_r <= 8'h00;
      first_r <= 11'h000;
      prev_r <= 11'h000;
      burst_len <= 8'h00;
      burst_first <= 11'h000;
      burst_last <= 11'h000;
      burst_num <= 8'h00;
      gap_errs <= 8'h00;
    end else begin
      dot_r <= dot_count_bits;
      gate_r <= refresh_gate;
      if (dot_count_bits == 4'h4 && dot_r != 4'h4 && refresh_gate) begin
        if (len_r == 8'h00) begin
          first_r <= refresh_addr;
        end else if (refresh_addr != tdg_addr_t'(prev_r + 11'h001)) begin
          gap_errs <= gap_errs + 8'h01;
        end
        prev_r <= refresh_addr;
        len_r <= len_r + 8'h01;
      end
      // Burst closes when the gate drops
      if (gate_r && !refresh_gate && len_r != 8'h00) begin
        burst_len <= len_r;
        burst_first <= first_r;
        burst_last <= prev_r;
        burst_num <= burst_num + 8'h01;
        len_r <= 8'h00;
      end
    end
  end
endmodule : tdg_refresh_model

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb;
  import tdg_pkg::*;

  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic caret_on_line = 1'b0;
  tdg_addr_t alt_addr = 11'h000;
  tdg_dot_t dot_count_bits;
  logic last_dot_flag;
  logic dot_tick;
  tdg_char_t char_count_bits;
  tdg_row_t row_count_bits;
  tdg_line_t line_number_bits;
  logic cursor_row_latch;
  logic preset_load_window;
  logic refresh_gate;
  tdg_addr_t refresh_addr;
  logic [7:0] burst_len;
  logic [7:0] burst_num;
  logic [7:0] gap_errs;
  tdg_addr_t burst_first;
  tdg_addr_t burst_last;
  int error_cnt = 0;
  int n_tests = 0;

  always #2.5 sys_clk = ~sys_clk;

  tdg_display_timing u_tdg_display_timing (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .caret_on_line(caret_on_line),
    .alt_addr(alt_addr),
    .dot_count_bits(dot_count_bits),
    .last_dot_flag(last_dot_flag),
    .dot_tick(dot_tick),
    .char_count_bits(char_count_bits),
    .row_count_bits(row_count_bits),
    .line_number_bits(line_number_bits),
    .cursor_row_latch(cursor_row_latch),
    .preset_load_window(preset_load_window),
    .refresh_gate(refresh_gate),
    .refresh_addr(refresh_addr)
  );

  tdg_refresh_model u_tdg_refresh_model (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .dot_count_bits(dot_count_bits),
    .refresh_gate(refresh_gate),
    .refresh_addr(refresh_addr),
    .burst_len(burst_len),
    .burst_first(burst_first),
    .burst_last(burst_last),
    .burst_num(burst_num),
    .gap_errs(gap_errs)
  );

  // ---------------------------------------------------------------
  // Compare and close
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk_zero;
    check({dot_count_bits, char_count_bits, row_count_bits, line_number_bits,
           cursor_row_latch, preset_load_window, refresh_gate, last_dot_flag,
           dot_tick}, 32'h0);
    check(refresh_addr, 32'h0);
  endtask : chk_zero

  // Bounded wait for the next dot step
  task automatic wait_dot(input tdg_dot_t prev);
    int i;
    for (i = 0; i < 40; i++) begin
      @(negedge sys_clk);
      if (dot_count_bits !== prev) break;
    end
    check(i < 40, 1);
  endtask : wait_dot

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Walks counters and address bursts from a fresh reset
  task automatic t_counting(input int nchars);
    tdg_dot_t ed;
    tdg_char_t ec;
    tdg_row_t er;
    logic win;
    int k;
    ed = 4'h0;
    ec = 7'h00;
    er = 4'h0;
    k = 0;
    while (k < nchars) begin
      wait_dot(ed);
      ed = (ed == 4'h8) ? 4'h0 : ed + 4'h1;
      check(dot_count_bits, ed);
      check(last_dot_flag, ed == 4'h0);
      if (ed == 4'h0) begin
        k++;
        er = (ec == 7'h60) ? er + 4'h1 : er;
        ec = (ec == 7'h60) ? 7'h00 : ec + 7'h01;
        check(char_count_bits, ec);
        check(row_count_bits, er);
        check(line_number_bits, 32'h0);
        @(posedge sys_clk) alt_addr <= {ec, er};
      end
      if (ed == 4'h4) begin
        win = (ec >= 7'h4E) && (ec <= 7'h5E);
        check(preset_load_window, win);
        check(refresh_gate, !win && er < 4'hB);
        check(cursor_row_latch, 32'h0);
        if (win && ec >= 7'h50) check(refresh_addr, {ec, er});
        if (ec == 7'h4E) begin
          check(burst_num, er + 1);
          check(burst_len, (er == 4'h0) ? 78 : 80);
          check(burst_first, 32'h0);
          check(burst_last, (er == 4'h0) ? 77 : 79);
          check(gap_errs, 32'h0);
        end
      end
    end
  endtask : t_counting

  // Average dot rate over a fixed span
  task automatic t_rate;
    int n;
    n = 0;
    repeat (20000) begin
      @(negedge sys_clk);
      if (dot_tick === 1'b1) n++;
    end
    check(n >= 1348 && n <= 1349, 1);
  endtask : t_rate

  // Reset in mid-run clears everything, then counting restarts
  task automatic t_mid_reset;
    @(posedge sys_clk) resetn <= 1'b0;
    @(negedge sys_clk);
    chk_zero();
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    t_counting(100);
  endtask : t_mid_reset

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (11) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_zero();
    @(posedge sys_clk);
    resetn <= 1'b1;
    caret_on_line <= 1'b1;
    t_counting(274);
    t_rate();
    t_mid_reset();
    test_done();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end
endmodule : tb

`default_nettype wire
